// ### hdl/pccr_pkg.sv
// Package with the clock-generator register map, fields and reset values
// Notes on behaviour
// - The clock registers are decoded in I/O space at 1C80h, 1C82h, 1C88h-1C92h, 1C98h, 8400h and 8C00h.
// - In the control/status register, bits 15:7 and bit 4 read as zero and ignore writes.
// - Bit 6 is a read-only oscillator-stable flag that reads 0 until the oscillator counter has counted 41,032 reference cycles.
// - The stable flag reads 1 when the counter is done, the counter is disabled, or test mode is active.
// - Bit 5 is a read-only lock flag that reads 0 while the PLL acquires lock and resets to 0.
// - The lock flag goes to 1 only once the PLL is locked at the programmed multiplier and prescaler.
// - Bit 3 is the PLL reset control, read/write, reset 1; 1 holds the PLL in reset and 0 releases it.
// - With oscillator power-down set and the clock-mode select bit 0, the oscillator powers down only when the clock generator is idle.
// - With the clock-mode select bit 1, the oscillator powers down as soon as the power-down bit is written 1; 0 keeps it running.
// - Bit 1 set places the PLL in power-down; cleared, which is its reset value, the PLL runs.
// - Bit 0, the PLL enable, drives the source multiplexer of the three system dividers and resets to 0.
// - With the PLL enable at 0 the PLL and first divider are bypassed and all system clocks come from the reference clock.
// - With the PLL enable at 1 the PLL output goes through the first divider and feeds all three system clocks.
package pccr_pkg;
  localparam int PCCR_AW = 16;
  localparam int PCCR_DW = 16;
  // I/O-space register offsets
  localparam logic [15:0] PCCR_PLL_CONTROL_STATUS = 16'h1C80;
  localparam logic [15:0] PCCR_CORE_CLOCK_SOURCE_SELECT = 16'h1C82;
  localparam logic [15:0] PCCR_PLL_MULTIPLIER = 16'h1C88;
  localparam logic [15:0] PCCR_PRESCALER_DIVIDER = 16'h1C8A;
  localparam logic [15:0] PCCR_FAST_GROUP_DIVIDER = 16'h1C8C;
  localparam logic [15:0] PCCR_SLOW_GROUP_DIVIDER = 16'h1C8E;
  localparam logic [15:0] PCCR_MEMORY_GROUP_DIVIDER = 16'h1C90;
  localparam logic [15:0] PCCR_OSCILLATOR_DIVIDER = 16'h1C92;
  localparam logic [15:0] PCCR_WAKEUP_ENABLE = 16'h1C98;
  localparam logic [15:0] PCCR_CLOCK_OUTPUT_SELECT = 16'h8400;
  localparam logic [15:0] PCCR_CLOCK_MODE_CONTROL = 16'h8C00;
  // Control/status and clock-mode control field positions
  localparam int PCCR_BIT_STABLE = 6;
  localparam int PCCR_BIT_LOCK = 5;
  localparam int PCCR_BIT_PLL_RESET = 3;
  localparam int PCCR_BIT_OSC_PWRDN = 2;
  localparam int PCCR_BIT_PLL_PWRDN = 1;
  localparam int PCCR_BIT_PLL_ENABLE = 0;
  localparam int PCCR_BIT_CLOCK_MODE_SELECT = 0;
  localparam logic [15:0] PCCR_CSR_WMASK = 16'h000F;
  // Reset values of the control bits and the generic registers
  localparam logic PCCR_RST_PLL_RESET = 1'b1;
  localparam logic PCCR_RST_OSC_PWRDN = 1'b0;
  localparam logic PCCR_RST_PLL_PWRDN = 1'b0;
  localparam logic PCCR_RST_PLL_ENABLE = 1'b0;
  localparam logic [15:0] PCCR_RST_GENERIC = 16'h0000;
  // Oscillator settle count in reference cycles
  localparam int PCCR_OSC_SETTLE_CYCLES = 41032;
  // Default lock acquisition time in device cycles
  localparam int PCCR_LOCK_CYCLES = 64;
  localparam int PCCR_CNT_W = 16;
endpackage : pccr_pkg

// ### hdl/pccr_counter.sv
// Saturating done-counter used for oscillator settle and PLL lock timing
`timescale 1ns/1ns
module pccr_counter #(
  parameter int WIDTH = 16,
  parameter int TERMINAL = 100
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  input wire logic count_en_i,
  output logic done_o
);
  initial begin
    if (TERMINAL < 1 || TERMINAL >= (1 << WIDTH)) begin
      $error("pccr_counter: TERMINAL does not fit WIDTH");
    end
  end

  logic [WIDTH-1:0] count_q;
  localparam logic [WIDTH-1:0] LAST = WIDTH'(TERMINAL - 1);

  // Count up and hold at the terminal; clear restarts the wait
  always_ff @(posedge clock_i) begin
    if (!resetn_i || clear_i) begin
      count_q <= '0;
      done_o <= 1'b0;
    end else if (count_en_i && !done_o) begin
      if (count_q == LAST) begin
        done_o <= 1'b1;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end
endmodule // pccr_counter

// ### hdl/pccr_regs.sv
// PLL clock-generator control and status registers
`timescale 1ns/1ns
module pccr_regs
  import pccr_pkg::*;
#(
  parameter int OSC_SETTLE = PCCR_OSC_SETTLE_CYCLES,
  parameter int LOCK_TIME = PCCR_LOCK_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [PCCR_AW-1:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [PCCR_DW-1:0] io_wdata_i,
  output logic [PCCR_DW-1:0] io_rdata_o,
  output logic io_hit_o,
  input wire logic ref_tick_i,
  input wire logic osc_counter_disable_i,
  input wire logic test_mode_i,
  input wire logic clock_idle_status_i,
  output logic pll_reset_o,
  output logic pll_power_down_o,
  output logic oscillator_power_down_o,
  output logic pll_enable_o,
  output logic pll_lock_o,
  output logic [PCCR_DW-1:0] pll_multiplier_o,
  output logic [PCCR_DW-1:0] prescaler_divider_o,
  output logic [PCCR_DW-1:0] fast_group_divider_o,
  output logic [PCCR_DW-1:0] slow_group_divider_o,
  output logic [PCCR_DW-1:0] memory_group_divider_o,
  output logic [PCCR_DW-1:0] oscillator_divider_o,
  output logic [PCCR_DW-1:0] core_clock_source_select_o,
  output logic [PCCR_DW-1:0] wakeup_enable_o,
  output logic [PCCR_DW-1:0] clock_output_select_o,
  output logic [PCCR_DW-1:0] clock_mode_control_o
);
  initial begin
    if (OSC_SETTLE < 1 || OSC_SETTLE > 65535 || LOCK_TIME < 1 || LOCK_TIME > 65535) begin
      $error("pccr_regs: count parameters out of range");
    end
  end

  // Pin inputs pass a two-stage synchroniser
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {ref_tick_i, osc_counter_disable_i, test_mode_i, clock_idle_status_i};
      sync2_q <= sync1_q;
    end
  end
  logic ref_lvl, osc_dis, test_mode, clk_idle;
  assign {ref_lvl, osc_dis, test_mode, clk_idle} = sync2_q;

  // Reference edge detect, taken after the synchroniser
  logic ref_prev_q;
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_lvl;
    end
  end
  logic ref_edge;
  assign ref_edge = ref_lvl && !ref_prev_q;

  // Register write strobes
  logic wr_csr, wr_mode;
  assign wr_csr = io_wr_i && (io_addr_i == PCCR_PLL_CONTROL_STATUS);
  assign wr_mode = io_wr_i && (io_addr_i == PCCR_CLOCK_MODE_CONTROL);

  // Control bits of the control/status register; reserved bits not stored
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pll_reset_o <= PCCR_RST_PLL_RESET;
      pll_power_down_o <= PCCR_RST_PLL_PWRDN;
      pll_enable_o <= PCCR_RST_PLL_ENABLE;
    end else if (wr_csr) begin
      pll_reset_o <= io_wdata_i[PCCR_BIT_PLL_RESET];
      pll_power_down_o <= io_wdata_i[PCCR_BIT_PLL_PWRDN];
      pll_enable_o <= io_wdata_i[PCCR_BIT_PLL_ENABLE];
    end
  end

  // Oscillator power-down request bit
  logic osc_req_q;
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      osc_req_q <= PCCR_RST_OSC_PWRDN;
    end else if (wr_csr) begin
      osc_req_q <= io_wdata_i[PCCR_BIT_OSC_PWRDN];
    end
  end

  // Generic stored registers, one always_ff via generate over the map
  localparam int NGEN = 10;
  localparam logic [NGEN*16-1:0] GEN_ADDR = {
    PCCR_CORE_CLOCK_SOURCE_SELECT, PCCR_PLL_MULTIPLIER, PCCR_PRESCALER_DIVIDER,
    PCCR_FAST_GROUP_DIVIDER, PCCR_SLOW_GROUP_DIVIDER, PCCR_MEMORY_GROUP_DIVIDER,
    PCCR_OSCILLATOR_DIVIDER, PCCR_WAKEUP_ENABLE, PCCR_CLOCK_OUTPUT_SELECT,
    PCCR_CLOCK_MODE_CONTROL};
  logic [PCCR_DW-1:0] gen_q [NGEN];
  for (genvar g = 0; g < NGEN; g++) begin : g_reg
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        gen_q[g] <= PCCR_RST_GENERIC;
      end else if (io_wr_i && io_addr_i == GEN_ADDR[(NGEN-1-g)*16 +: 16]) begin
        gen_q[g] <= io_wdata_i;
      end
    end
  end
  assign core_clock_source_select_o = gen_q[0];
  assign pll_multiplier_o = gen_q[1];
  assign prescaler_divider_o = gen_q[2];
  assign fast_group_divider_o = gen_q[3];
  assign slow_group_divider_o = gen_q[4];
  assign memory_group_divider_o = gen_q[5];
  assign oscillator_divider_o = gen_q[6];
  assign wakeup_enable_o = gen_q[7];
  assign clock_output_select_o = gen_q[8];
  assign clock_mode_control_o = gen_q[9];
  logic mode_sel;
  assign mode_sel = gen_q[9][PCCR_BIT_CLOCK_MODE_SELECT];

  // Oscillator power-down: immediate in mode 1, waits for idle in mode 0
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      oscillator_power_down_o <= 1'b0;
    end else if (!osc_req_q) begin
      oscillator_power_down_o <= 1'b0;
    end else if (mode_sel) begin
      oscillator_power_down_o <= 1'b1;
    end else if (clk_idle) begin
      oscillator_power_down_o <= 1'b1;
    end else begin
      oscillator_power_down_o <= 1'b0;
    end
  end

  // Oscillator settle counter; restarts while the oscillator is down
  logic osc_done;
  pccr_counter #(
    .WIDTH(PCCR_CNT_W),
    .TERMINAL(OSC_SETTLE)
  ) u_osc_cnt (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .clear_i(oscillator_power_down_o),
    .count_en_i(ref_edge),
    .done_o(osc_done)
  );
  logic stable;
  assign stable = osc_done || osc_dis || test_mode;

  // Lock timer; settings changes restart acquisition
  logic setting_chg;
  assign setting_chg = io_wr_i && (io_addr_i == PCCR_PLL_MULTIPLIER ||
                                   io_addr_i == PCCR_PRESCALER_DIVIDER);
  logic lock_done;
  pccr_counter #(
    .WIDTH(PCCR_CNT_W),
    .TERMINAL(LOCK_TIME)
  ) u_lock_cnt (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .clear_i(pll_reset_o || pll_power_down_o || setting_chg),
    .count_en_i(1'b1),
    .done_o(lock_done)
  );
  // Lock flag registered; cleared one cycle after the PLL reset or power-down output goes high
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pll_lock_o <= 1'b0;
    end else if (pll_reset_o || pll_power_down_o || setting_chg) begin
      pll_lock_o <= 1'b0;
    end else begin
      pll_lock_o <= lock_done;
    end
  end

  // Read mux, registered; unmapped reads return zero with no hit
  logic [PCCR_DW-1:0] csr_view;
  always_comb begin
    csr_view = 16'h0000;
    csr_view[PCCR_BIT_STABLE] = stable;
    csr_view[PCCR_BIT_LOCK] = pll_lock_o;
    csr_view[PCCR_BIT_PLL_RESET] = pll_reset_o;
    csr_view[PCCR_BIT_OSC_PWRDN] = osc_req_q;
    csr_view[PCCR_BIT_PLL_PWRDN] = pll_power_down_o;
    csr_view[PCCR_BIT_PLL_ENABLE] = pll_enable_o;
  end
  logic [PCCR_DW-1:0] rd_d;
  logic hit_d;
  always_comb begin
    rd_d = 16'h0000;
    hit_d = 1'b0;
    if (io_addr_i == PCCR_PLL_CONTROL_STATUS) begin
      rd_d = csr_view;
      hit_d = 1'b1;
    end else begin
      for (int i = 0; i < NGEN; i++) begin
        if (io_addr_i == GEN_ADDR[(NGEN-1-i)*16 +: 16]) begin
          rd_d = gen_q[i];
          hit_d = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      io_rdata_o <= 16'h0000;
      io_hit_o <= 1'b0;
    end else begin
      io_rdata_o <= io_rd_i ? rd_d : 16'h0000;
      io_hit_o <= (io_rd_i || io_wr_i) && hit_d;
    end
  end

  // Checks
  sequence s_csr_wr_rst1;
    wr_csr && io_wdata_i[PCCR_BIT_PLL_RESET];
  endsequence
  chk_lock_clear_reset: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_csr_wr_rst1 |=> ##2 !pll_lock_o)
    else $error("lock flag not cleared under PLL reset");
  chk_lock_needs_time: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(pll_lock_o) |-> $past(!pll_reset_o, 2) && $past(!pll_power_down_o))
    else $error("lock rose without released PLL");
  chk_reserved_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
    io_rdata_o[15:7] == 9'h000 || !$past(io_addr_i == PCCR_PLL_CONTROL_STATUS))
    else $error("reserved status bits not zero");
  chk_bit4_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $past(io_rd_i && io_addr_i == PCCR_PLL_CONTROL_STATUS) |-> !io_rdata_o[4])
    else $error("bit 4 not zero");
  chk_stable_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
    io_rd_i && io_addr_i == PCCR_PLL_CONTROL_STATUS |=> io_rdata_o[6] == $past(stable))
    else $error("stable flag misreported");
  chk_stable_test: assert property (@(posedge clock_i) disable iff (!resetn_i)
    test_mode |-> stable)
    else $error("stable low in test mode");
  chk_enable_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
    wr_csr |=> pll_enable_o == $past(io_wdata_i[0]) && pll_power_down_o == $past(io_wdata_i[1]))
    else $error("enable or power-down not written");
  chk_osc_immediate: assert property (@(posedge clock_i) disable iff (!resetn_i)
    osc_req_q && mode_sel |=> oscillator_power_down_o)
    else $error("oscillator not powered down at once");
  chk_osc_wait_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
    osc_req_q && !mode_sel && !clk_idle |=> !oscillator_power_down_o)
    else $error("oscillator powered down before idle");
  chk_reset_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
    wr_csr |=> pll_reset_o == $past(io_wdata_i[3]))
    else $error("PLL reset bit not written");
endmodule // pccr_regs

// ### bench/testbench.sv
// Self-checking bench for the clock-generator register block
`timescale 1ns/1ns
module testbench;
  import pccr_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic io_rd_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic [15:0] io_wdata_i = 16'h0000;
  logic ref_tick_i = 1'b0;
  logic osc_counter_disable_i = 1'b0;
  logic test_mode_i = 1'b0;
  logic clock_idle_status_i = 1'b0;
  logic [15:0] io_rdata_o;
  logic [15:0] img [10];
  logic io_hit_o;
  logic pll_reset_o;
  logic pll_power_down_o;
  logic oscillator_power_down_o;
  logic pll_enable_o;
  logic pll_lock_o;
  logic [15:0] rdata_seen;
  logic hit_seen;
  logic [15:0] map_addr [10];
  int mismatches = 0;
  int n_tests = 0;

  // Short settle and lock counts keep the run brief
  pccr_regs #(.OSC_SETTLE(20), .LOCK_TIME(8)) u_pccr_regs (
    .clock_i(clock_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_hit_o(io_hit_o),
    .ref_tick_i(ref_tick_i), .osc_counter_disable_i(osc_counter_disable_i),
    .test_mode_i(test_mode_i), .clock_idle_status_i(clock_idle_status_i),
    .pll_reset_o(pll_reset_o), .pll_power_down_o(pll_power_down_o),
    .oscillator_power_down_o(oscillator_power_down_o), .pll_enable_o(pll_enable_o),
    .pll_lock_o(pll_lock_o), .pll_multiplier_o(img[1]), .prescaler_divider_o(img[2]),
    .fast_group_divider_o(img[3]), .slow_group_divider_o(img[4]),
    .memory_group_divider_o(img[5]), .oscillator_divider_o(img[6]),
    .core_clock_source_select_o(img[0]), .wakeup_enable_o(img[7]),
    .clock_output_select_o(img[8]), .clock_mode_control_o(img[9])
  );

  // 25 MHz device clock
  initial begin
    forever #20 clock_i = ~clock_i;
  end

  // Compare and count; unknowns never match
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Inputs move on the falling edge so the rising edge samples them cleanly
  task automatic io_write(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge clock_i);
    io_wr_i = 1'b0;
  endtask

  // Read data stands one cycle, so it is captured at the very next falling edge
  task automatic io_read(input logic [15:0] a);
    @(negedge clock_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge clock_i);
    io_rd_i = 1'b0;
    rdata_seen = io_rdata_o;
    hit_seen = io_hit_o;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Reference clock pulses, slow enough to survive the synchroniser
  task automatic tick(input int n);
    repeat (n) begin
      ref_tick_i = 1'b1;
      idle(2);
      ref_tick_i = 1'b0;
      idle(2);
    end
  endtask

  // Bounded poll; a run-out ends the run
  task automatic wait_lock(input logic exp);
    int k;
    for (k = 0; k < 40 && pll_lock_o !== exp; k++) @(negedge clock_i);
    check("lock wait", {15'h0000, exp}, {15'h0000, pll_lock_o});
    if (pll_lock_o !== exp) summarize();
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    map_addr = '{PCCR_CORE_CLOCK_SOURCE_SELECT, PCCR_PLL_MULTIPLIER, PCCR_PRESCALER_DIVIDER,
      PCCR_FAST_GROUP_DIVIDER, PCCR_SLOW_GROUP_DIVIDER, PCCR_MEMORY_GROUP_DIVIDER,
      PCCR_OSCILLATOR_DIVIDER, PCCR_WAKEUP_ENABLE, PCCR_CLOCK_OUTPUT_SELECT,
      PCCR_CLOCK_MODE_CONTROL};
    idle(5);
    resetn_i = 1'b1;
    // Reset image: only the PLL reset bit is set
    io_read(PCCR_PLL_CONTROL_STATUS);
    check("csr reset", 16'h0008, rdata_seen);
    check("csr hit", 16'h0001, {15'h0000, hit_seen});
    check("pll reset out", 16'h0001, {15'h0000, pll_reset_o});
    $display("test reset done");
    // Every mapped register other than the control/status register resets to zero and holds what is written
    for (int i = 0; i < 10; i++) begin
      io_read(map_addr[i]);
      check("map reset", 16'h0000, rdata_seen);
      io_write(map_addr[i], 16'h0101 * 16'(i + 1));
      io_read(map_addr[i]);
      check("map readback", 16'h0101 * 16'(i + 1), rdata_seen);
      check("map hit", 16'h0001, {15'h0000, hit_seen});
      check("map out", 16'h0101 * 16'(i + 1), img[i]);
    end
    check("multiplier out", 16'h0202, img[1]);
    io_write(16'h1C84, 16'hFFFF);
    io_read(16'h1C84);
    check("hole read", 16'h0000, rdata_seen);
    check("hole hit", 16'h0000, {15'h0000, hit_seen});
    $display("test map done");
    // Reserved and status bits ignore writes
    io_write(PCCR_PLL_CONTROL_STATUS, 16'hFFFF);
    io_read(PCCR_PLL_CONTROL_STATUS);
    check("csr mask", 16'h000F, rdata_seen);
    check("enable out", 16'h0001, {15'h0000, pll_enable_o});
    check("pll pd out", 16'h0001, {15'h0000, pll_power_down_o});
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0008);
    $display("test reserved done");
    // Stable flag: forced by test mode or counter disable, else by the count
    test_mode_i = 1'b1;
    idle(5);
    io_read(PCCR_PLL_CONTROL_STATUS);
    check("stable test mode", 16'h0048, rdata_seen);
    test_mode_i = 1'b0;
    osc_counter_disable_i = 1'b1;
    idle(5);
    io_read(PCCR_PLL_CONTROL_STATUS);
    check("stable disabled", 16'h0048, rdata_seen);
    osc_counter_disable_i = 1'b0;
    tick(19);
    io_read(PCCR_PLL_CONTROL_STATUS);
    check("stable early", 16'h0008, rdata_seen);
    tick(1);
    idle(4);
    io_read(PCCR_PLL_CONTROL_STATUS);
    check("stable counted", 16'h0048, rdata_seen);
    $display("test stable done");
    // Oscillator power-down waits for idle unless the mode bit says at once
    io_write(PCCR_CLOCK_MODE_CONTROL, 16'h0000);
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h000C);
    idle(5);
    check("osc pd not idle", 16'h0000, {15'h0000, oscillator_power_down_o});
    clock_idle_status_i = 1'b1;
    idle(5);
    check("osc pd idle", 16'h0001, {15'h0000, oscillator_power_down_o});
    clock_idle_status_i = 1'b0;
    idle(5);
    check("osc pd awake", 16'h0000, {15'h0000, oscillator_power_down_o});
    io_write(PCCR_CLOCK_MODE_CONTROL, 16'h0001);
    idle(1);
    check("osc pd now", 16'h0001, {15'h0000, oscillator_power_down_o});
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0008);
    idle(1);
    check("osc running", 16'h0000, {15'h0000, oscillator_power_down_o});
    $display("test oscillator done");
    // Reprogramming sequence, then each way of losing lock
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0008);
    io_write(PCCR_PLL_MULTIPLIER, 16'h0005);
    io_write(PCCR_PRESCALER_DIVIDER, 16'h0001);
    idle(25);
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0000);
    check("lock early", 16'h0000, {15'h0000, pll_lock_o});
    wait_lock(1'b1);
    io_read(PCCR_PLL_CONTROL_STATUS);
    check("csr locked", 16'h0020, rdata_seen & 16'h003F);
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0001);
    check("pll mode", 16'h0001, {15'h0000, pll_enable_o});
    io_write(PCCR_PRESCALER_DIVIDER, 16'h0002);
    idle(2);
    check("lock after retune", 16'h0000, {15'h0000, pll_lock_o});
    wait_lock(1'b1);
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0003);
    idle(2);
    check("lock pd", 16'h0000, {15'h0000, pll_lock_o});
    check("pd out", 16'h0001, {15'h0000, pll_power_down_o});
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0001);
    wait_lock(1'b1);
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0009);
    idle(2);
    check("lock in reset", 16'h0000, {15'h0000, pll_lock_o});
    check("reset out", 16'h0001, {15'h0000, pll_reset_o});
    io_write(PCCR_PLL_CONTROL_STATUS, 16'h0008);
    check("bypass", 16'h0000, {15'h0000, pll_enable_o});
    $display("test lock done");
    summarize();
  end
endmodule // testbench
